// ==== tcr_pkg.sv ====
/*
 * tcr_pkg: constants, field layouts and carrier types for the transceiver
 * configuration bank (registers one to four).
 * assumes: one 50 MHz system clock; serial pins already synchronous.
 */
package tcr_pkg;
    // ------------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------------
    localparam int WORD_W      = 24;   // serial word length
    localparam int BIT_CFG     = 23;   // configuration word marker
    localparam int BIT_RST     = 22;   // reset-to-defaults request
    localparam int BIT_WEN     = 21;   // write enable marker
    localparam int ADDR_HI     = 20;   // address field top
    localparam int ADDR_LO     = 16;   // address field bottom
    localparam int DATA_W      = 16;   // register data width
    localparam int ADDR_W      = 5;    // address field width
    // register addresses
    localparam logic [4:0] ADDR_CLK_TX = 5'h01;
    localparam logic [4:0] ADDR_SWITCH = 5'h02;
    localparam logic [4:0] ADDR_PLLOFS = 5'h03;
    localparam logic [4:0] ADDR_DEVIAT = 5'h04;
    // reset values
    localparam logic [15:0] RST_CLK_TX = 16'h8080;
    localparam logic [15:0] RST_SWITCH = 16'h4080;
    localparam logic [15:0] RST_PLLOFS = 16'h0086;
    localparam logic [7:0]  RST_DEV_LO = 8'h00;
    // deviation power-on values by rate
    localparam logic [7:0] DEV_RATE0 = 8'h38;
    localparam logic [7:0] DEV_RATE1 = 8'h45;
    localparam logic [7:0] DEV_RATE2 = 8'h5D;
    localparam logic [7:0] DEV_RATE3 = 8'h60;
    localparam logic [7:0] DEV_RATE4 = 8'h50;
    localparam logic [7:0] DEV_UNDEF = 8'h00;
    // regulator code that must never be stored
    localparam logic [1:0] REG_CODE_BAD = 2'h1;
    // sequencer delay unit
    localparam int UNIT_NS      = 1000;  // one delay step, ns
    localparam int CLK_NS       = 20;    // system clock period, ns
    localparam int UNIT_CYCLES  = (UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W       = 8;

    // ------------------------------------------------------------------
    // decoded configuration fields
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] recovered_clock_delay_code;
        logic       recovered_clock_delay_enable;
        logic [2:0] pa_bias_code;
        logic       signal_strength_mask;
        logic       amplifier_before_switch;
        logic       tx_sample_edge_select;
        logic       tx_data_invert;
        logic       skip_oscillator_recal;
        logic       sync_word_one_error_allow;
        logic [1:0] regulator_voltage_code;
        logic       analog_output_select;
        logic [4:0] amp_on_to_switch_delay;
        logic [1:0] amp_off_to_switch_delay;
        logic [5:0] receive_to_transmit_delay;
        logic [3:0] divider_integer_offset;
        logic [7:0] deviation_value;
    } tcr_cfg_type;

    // serial pins
    typedef struct packed {
        logic sclk;   // shift clock, data taken on its rise
        logic sdata;  // data, msb first
        logic latch;  // rise ends a word
    } tcr_serial_type;
endpackage

// ==== tcr_config_bank.sv ====
/*
 * tcr_config_bank: serial-written configuration registers one to four
 * and the small pieces of logic they steer directly.
 * assumes: serial pins and tx data synchronous to sys_clk_i; the rate
 * selection comes from register zero, held elsewhere.
 */
//
// Contract
// [R1] 4-bit recovered clock delay code, default 8
// [R2] enable bit applies delay; default off
// [R3] pa bias code, codes 3/4 equal
// [R4] mask rssi until pll tuned, default on
// [R5] pa-first bit orders pa versus switch
// [R6] edge bit picks tx sample edge
// [R7] polarity bit inverts tx data
// [R8] skip bit drops oscillator recalibration only
// [R9] tolerance bit allows one sync error
// [R10] regulator code; code 1 never stored
// [R11] select bit picks analog or digital out
// [R12] 5-bit pa-on to switch delay
// [R13] 2-bit pa-off to switch delay, default 2
// [R14] 6-bit receive to transmit delay
// [R15] 4-bit divider integer offset, default 8
// [R16] 8-bit deviation in upper byte
// [R17] deviation default follows rate at reset
// [R18] controller writes recommended values
// [R19] word: bit23, bit21 set, address, data
// [R20] controller writes only while chip inactive
// [R21] bit 22 reloads all defaults
// [R22] controller writes reserved fields at defaults
`timescale 1ns/1ps
module tcr_config_bank #(
    parameter int UNIT_CYC = tcr_pkg::UNIT_CYCLES  // cycles per delay step
) (
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_i,
    // serial control pins
    input  wire tcr_pkg::tcr_serial_type ser_i,
    input  wire logic                   chip_active_input_i,
    input  wire logic [2:0]             rate_sel_i,
    // status from analog side
    input  wire logic                   pll_tuned_i,
    input  wire logic                   ref_clk_i,
    input  wire logic                   tx_data_i,
    input  wire logic                   tx_req_i,
    // configuration out
    output tcr_pkg::tcr_cfg_type        cfg_o,
    output logic [3:0]                  clk_delay_applied_o,
    output logic [2:0]                  pa_bias_level_o,
    output logic                        rssi_enable_o,
    output logic                        tx_filter_data_o,
    output logic                        vco_recal_en_o,
    output logic                        if_recal_en_o,
    output logic                        uw_max_errors_o,
    output logic                        analog_out_en_o,
    output logic                        digital_out_en_o,
    output logic                        pa_on_o,
    output logic                        tr_switch_tx_o
);
    import tcr_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // deviation default by rate selection
    function automatic logic [7:0] dev_default(input logic [2:0] r);
        case (r)
            3'h0:    dev_default = DEV_RATE0;
            3'h1:    dev_default = DEV_RATE1;
            3'h2:    dev_default = DEV_RATE2;
            3'h3:    dev_default = DEV_RATE3;
            3'h4:    dev_default = DEV_RATE4;
            default: dev_default = DEV_UNDEF;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] shift;      // incoming word
    logic              sclk_q;     // previous shift clock
    logic              latch_q;    // previous latch
    logic              word_done;  // latch rise
    logic [ADDR_W-1:0] waddr;      // decoded address
    logic              is_write;   // valid register write
    logic              is_reset;   // defaults request

    // shift msb first on shift clock rise
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shift   <= '0;
            sclk_q  <= 1'b0;
            latch_q <= 1'b0;
        end
        else
        begin
            sclk_q  <= ser_i.sclk;
            latch_q <= ser_i.latch;
            if (ser_i.sclk && !sclk_q)
                shift <= {shift[WORD_W-2:0], ser_i.sdata};
        end
    end

    assign word_done = ser_i.latch && !latch_q;
    assign waddr     = shift[ADDR_HI:ADDR_LO];
    // configuration word, standby only
    assign is_reset  = word_done && shift[BIT_CFG] && shift[BIT_RST] // [R21]
                       && !chip_active_input_i;                      // [R20]
    assign is_write  = word_done && shift[BIT_CFG] && shift[BIT_WEN] // [R19]
                       && !shift[BIT_RST] && !chip_active_input_i;   // [R20]

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] reg_clk_tx;   // clock recovery and tx control
    logic [DATA_W-1:0] reg_switch;   // output select and switch delays
    logic [DATA_W-1:0] reg_pllofs;   // pll integer offset
    logic [DATA_W-1:0] reg_deviat;   // modulation deviation
    logic              dev_pending;  // deviation default still to load

    // deviation takes rate default after any reset
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            dev_pending <= 1'b1;
        else
            dev_pending <= is_reset;                   // [R17]
    end

    // register writes; a reset word reloads defaults
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_clk_tx <= RST_CLK_TX;                  // [R1] [R2] [R4]
            reg_switch <= RST_SWITCH;                  // [R13]
            reg_pllofs <= RST_PLLOFS;                  // [R15]
            reg_deviat <= '0;
        end
        else if (is_reset)
        begin
            reg_clk_tx <= RST_CLK_TX;                  // [R21]
            reg_switch <= RST_SWITCH;
            reg_pllofs <= RST_PLLOFS;
        end
        else if (dev_pending)
            reg_deviat <= {dev_default(rate_sel_i), RST_DEV_LO}; // [R17]
        else if (is_write)
        begin
            case (waddr)
                ADDR_CLK_TX:
                begin
                    reg_clk_tx[15:2] <= shift[15:2];
                    // forbidden regulator code keeps old value
                    if (shift[1:0] != REG_CODE_BAD)    // [R10]
                        reg_clk_tx[1:0] <= shift[1:0];
                end
                ADDR_SWITCH: reg_switch <= shift[15:0];
                ADDR_PLLOFS: reg_pllofs <= shift[15:0];
                ADDR_DEVIAT: reg_deviat <= shift[15:0]; // [R16]
                default:     ;                          // other addresses
            endcase
        end
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    always_comb
    begin
        cfg_o.recovered_clock_delay_code   = reg_clk_tx[15:12]; // [R1]
        cfg_o.recovered_clock_delay_enable = reg_clk_tx[11];    // [R2]
        cfg_o.pa_bias_code                 = reg_clk_tx[10:8];  // [R3]
        cfg_o.signal_strength_mask         = reg_clk_tx[7];     // [R4]
        cfg_o.amplifier_before_switch      = reg_clk_tx[6];     // [R5]
        cfg_o.tx_sample_edge_select        = reg_clk_tx[5];     // [R6]
        cfg_o.tx_data_invert               = reg_clk_tx[4];     // [R7]
        cfg_o.skip_oscillator_recal        = reg_clk_tx[3];     // [R8]
        cfg_o.sync_word_one_error_allow    = reg_clk_tx[2];     // [R9]
        cfg_o.regulator_voltage_code       = reg_clk_tx[1:0];   // [R10]
        cfg_o.analog_output_select         = reg_switch[13];    // [R11]
        cfg_o.amp_on_to_switch_delay       = reg_switch[12:8];  // [R12]
        cfg_o.amp_off_to_switch_delay      = reg_switch[7:6];   // [R13]
        cfg_o.receive_to_transmit_delay    = reg_switch[5:0];   // [R14]
        cfg_o.divider_integer_offset       = reg_pllofs[7:4];   // [R15]
        cfg_o.deviation_value              = reg_deviat[15:8];  // [R16]
    end

    // delay applied only when enabled
    assign clk_delay_applied_o = cfg_o.recovered_clock_delay_enable
                                 ? cfg_o.recovered_clock_delay_code
                                 : 4'h0;                          // [R2]
    // monotonic bias level, codes 3 and 4 merge
    assign pa_bias_level_o = (cfg_o.pa_bias_code > 3'h3)
                             ? cfg_o.pa_bias_code - 3'h1
                             : cfg_o.pa_bias_code;                // [R3]
    assign rssi_enable_o    = !cfg_o.signal_strength_mask
                              || pll_tuned_i;                     // [R4]
    assign vco_recal_en_o   = !cfg_o.skip_oscillator_recal;      // [R8]
    assign if_recal_en_o    = 1'b1;                              // [R8]
    assign uw_max_errors_o  = cfg_o.sync_word_one_error_allow;   // [R9]
    assign analog_out_en_o  = cfg_o.analog_output_select;        // [R11]
    assign digital_out_en_o = !cfg_o.analog_output_select;       // [R11]

    // ------------------------------------------------------------------
    // tx data capture on chosen reference edge
    // ------------------------------------------------------------------
    logic ref_q;     // previous reference level
    logic ref_edge;  // selected edge seen

    assign ref_edge = cfg_o.tx_sample_edge_select
                      ? (!ref_clk_i && ref_q)                     // [R6]
                      : (ref_clk_i && !ref_q);                    // [R6]

    // sample and optionally invert tx data
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ref_q            <= 1'b0;
            tx_filter_data_o <= 1'b0;
        end
        else
        begin
            ref_q <= ref_clk_i;
            if (ref_edge)
                tx_filter_data_o <= tx_data_i ^ cfg_o.tx_data_invert; // [R7]
        end
    end

    // ------------------------------------------------------------------
    // pa and switch sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_RX2TX, SEQ_GAP, SEQ_ON, SEQ_OFF
    } tcr_seq_type;

    tcr_seq_type       seq;      // sequencer state
    logic [TICK_W-1:0] tick;     // cycles within one step
    logic [5:0]        steps;    // steps elapsed
    logic              step_p;   // one-step pulse

    assign step_p = (tick == TICK_W'(UNIT_CYC - 1));

    // step divider, held clear in idle and on states, restarts after each step
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            tick <= '0;
        else if (step_p || seq == SEQ_IDLE || seq == SEQ_ON)
            tick <= '0;
        else
            tick <= tick + 1'b1;
    end

    // state, step counter and outputs
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            seq            <= SEQ_IDLE;
            steps          <= '0;
            pa_on_o        <= 1'b0;
            tr_switch_tx_o <= 1'b0;
        end
        else
        begin
            case (seq)
                SEQ_IDLE:
                    if (tx_req_i)
                    begin
                        seq   <= SEQ_RX2TX;
                        steps <= '0;
                    end
                // wait receive to transmit delay
                SEQ_RX2TX:
                    if (steps == cfg_o.receive_to_transmit_delay)  // [R14]
                    begin
                        seq   <= SEQ_GAP;
                        steps <= '0;
                        if (cfg_o.amplifier_before_switch)         // [R5]
                            pa_on_o <= 1'b1;
                        else
                            tr_switch_tx_o <= 1'b1;
                    end
                    else if (step_p)
                        steps <= steps + 1'b1;
                // gap between pa and switch change
                SEQ_GAP:
                    if (steps == {1'b0, cfg_o.amp_on_to_switch_delay}) // [R12]
                    begin
                        seq            <= SEQ_ON;
                        pa_on_o        <= 1'b1;
                        tr_switch_tx_o <= 1'b1;
                    end
                    else if (step_p)
                        steps <= steps + 1'b1;
                SEQ_ON:
                    if (!tx_req_i)
                    begin
                        seq     <= SEQ_OFF;
                        steps   <= '0;
                        pa_on_o <= 1'b0;
                    end
                // pa off, then switch back after delay
                SEQ_OFF:
                    if (steps == {4'h0, cfg_o.amp_off_to_switch_delay}) // [R13]
                    begin
                        seq            <= SEQ_IDLE;
                        tr_switch_tx_o <= 1'b0;
                    end
                    else if (step_p)
                        steps <= steps + 1'b1;
                default: seq <= SEQ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_write_lands;
        @(posedge sys_clk_i) disable iff (rst_i)
        (is_write && waddr == ADDR_SWITCH && !dev_pending)
        |=> reg_switch == $past(shift[15:0]);
    endproperty
    a_write_lands: assert property (p_write_lands)        // [R19]
        else $error("register two write lost");

    property p_active_blocks;
        @(posedge sys_clk_i) disable iff (rst_i)
        (word_done && chip_active_input_i)
        |=> $stable(reg_clk_tx) && $stable(reg_switch)
            && $stable(reg_pllofs) && $stable(reg_deviat);
    endproperty
    a_active_blocks: assert property (p_active_blocks)    // [R20]
        else $error("write taken while chip active");

    property p_reset_word;
        @(posedge sys_clk_i) disable iff (rst_i)
        is_reset |=> (reg_clk_tx == RST_CLK_TX && reg_pllofs == RST_PLLOFS)
                     ##1 (cfg_o.deviation_value
                          == dev_default($past(rate_sel_i)));
    endproperty
    a_reset_word: assert property (p_reset_word)          // [R21] [R17]
        else $error("reset word defaults wrong");

    property p_bad_reg_code;
        @(posedge sys_clk_i) disable iff (rst_i)
        cfg_o.regulator_voltage_code != REG_CODE_BAD;
    endproperty
    a_bad_reg_code: assert property (p_bad_reg_code)      // [R10]
        else $error("invalid regulator code stored");

    property p_rssi_mask;
        @(posedge sys_clk_i) disable iff (rst_i)
        (cfg_o.signal_strength_mask && !pll_tuned_i) |-> !rssi_enable_o;
    endproperty
    a_rssi_mask: assert property (p_rssi_mask)            // [R4]
        else $error("rssi open during pll tuning");

    property p_tx_invert;
        @(posedge sys_clk_i) disable iff (rst_i)
        ref_edge |=> tx_filter_data_o ==
                     ($past(tx_data_i) ^ $past(cfg_o.tx_data_invert));
    endproperty
    a_tx_invert: assert property (p_tx_invert)            // [R7] [R6]
        else $error("tx data capture wrong");

    property p_order;
        @(posedge sys_clk_i) disable iff (rst_i)
        (seq == SEQ_GAP && $changed(seq))
        |-> (pa_on_o == cfg_o.amplifier_before_switch)
            && (tr_switch_tx_o != cfg_o.amplifier_before_switch);
    endproperty
    a_order: assert property (p_order)                    // [R5]
        else $error("pa and switch order wrong");

    property p_bias_merge;
        @(posedge sys_clk_i) disable iff (rst_i)
        (cfg_o.pa_bias_code == 3'h3 || cfg_o.pa_bias_code == 3'h4)
        |-> pa_bias_level_o == 3'h3;
    endproperty
    a_bias_merge: assert property (p_bias_merge)          // [R3]
        else $error("bias codes three and four differ");

    property p_delay_gate;
        @(posedge sys_clk_i) disable iff (rst_i)
        !cfg_o.recovered_clock_delay_enable |-> clk_delay_applied_o == 4'h0;
    endproperty
    a_delay_gate: assert property (p_delay_gate)          // [R2]
        else $error("delay applied while disabled");

endmodule // tcr_config_bank

// ==== tcr_serial_master.sv ====
/*
 * tcr_serial_master: behavioural baseband controller on the serial pins.
 * assumes: sys_clk_i from the bench; words handed in by task call.
 */
`timescale 1ns/1ps
module tcr_serial_master (
    // clock
    input  wire logic               sys_clk_i,
    // serial pins
    output tcr_pkg::tcr_serial_type ser_o
);
    import tcr_pkg::*;
    // idle: shift clock and latch low
    initial ser_o = '0;
    // one word, msb first, each level held one clock
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge sys_clk_i);
            #1;
            ser_o.sclk  = 1'b0;
            ser_o.sdata = w[i];
            @(posedge sys_clk_i);
            #1;
            ser_o.sclk = 1'b1;
        end
        @(posedge sys_clk_i);
        #1;
        ser_o.sclk  = 1'b0;
        ser_o.latch = 1'b1;
        @(posedge sys_clk_i);
        #1;
        ser_o.latch = 1'b0;
        // released data line no longer shows the last bit
        ser_o.sdata = ~w[0];
    endtask
endmodule // tcr_serial_master

// ==== tb_tcr_config_bank.sv ====
/*
 * tb_tcr_config_bank: serial write sequences with expected values.
 * assumes: tcr_pkg and tcr_serial_master compiled first.
 */
`timescale 1ns/1ps
module tb_tcr_config_bank;
    import tcr_pkg::*;
    localparam int UNIT = 2; // short delay step
    // design inputs and outputs
    logic           sys_clk_i = 1'b0;
    logic           rst_i     = 1'b1;
    tcr_serial_type ser;
    logic           act = 1'b0;
    logic [2:0]     rate = 3'h2;
    logic           tuned = 1'b0;
    logic           ref_clk = 1'b0;
    logic           txd = 1'b0;
    logic           txr = 1'b0;
    tcr_cfg_type    cfg;
    logic [3:0]     dly;
    logic [2:0]     bias;
    logic           rssi, txf, vco, ifc, uw, ana, dig, pa, sw;
    int             failures = 0;
    int             total_checks = 0;
    int             n;
    logic [7:0]     dev_tab [8] = '{8'h38, 8'h45, 8'h5D, 8'h60,
                                    8'h50, 8'h00, 8'h00, 8'h00};
    always #10 sys_clk_i = ~sys_clk_i;
    tcr_serial_master tcr_serial_master_i (.sys_clk_i(sys_clk_i),
        .ser_o(ser));
    tcr_config_bank #(.UNIT_CYC(UNIT)) tcr_config_bank_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ser_i(ser),
        .chip_active_input_i(act), .rate_sel_i(rate),
        .pll_tuned_i(tuned), .ref_clk_i(ref_clk), .tx_data_i(txd),
        .tx_req_i(txr), .cfg_o(cfg), .clk_delay_applied_o(dly),
        .pa_bias_level_o(bias), .rssi_enable_o(rssi),
        .tx_filter_data_o(txf), .vco_recal_en_o(vco),
        .if_recal_en_o(ifc), .uw_max_errors_o(uw),
        .analog_out_en_o(ana), .digital_out_en_o(dig),
        .pa_on_o(pa), .tr_switch_tx_o(sw));
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic raw(input logic [23:0] w);
        tcr_serial_master_i.send(w);
        step(3);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        raw({3'b101, a, d});
    endtask
    // bounded wait on pa or switch, or on both when both is set, reaching a level
    task automatic wait_out(input logic lv, input logic both);
        n = 0;
        while (((pa !== lv) && (sw !== lv) || both && (pa !== sw))
               && n < 200)
        begin
            step(1);
            n++;
        end
        if (n == 200)
        begin
            chk("sequencer wait", 0, 1);
            stop_test();
        end
    endtask
    // one transmit request, checks order and delays
    task automatic seq_run(input logic pf);
        wr(ADDR_CLK_TX, {8'h80, 1'b0, pf, 6'h02});
        txr = 1'b1;
        wait_out(1'b1, 1'b0);
        chk("rx to tx delay", 1, n >= 18 && n <= 54);
        chk("pa first", pf, pa);
        chk("switch first", !pf, sw);
        wait_out(1'b1, 1'b1);
        chk("pa to switch delay", 1, n >= 3 && n <= 9);
        txr = 1'b0;
        wait_out(1'b0, 1'b1);
        chk("pa off to switch delay", 1, n >= 3 && n <= 5);
    endtask
    initial
    begin
        step(3);
        rst_i = 1'b0;
        step(3);
        chk("deviation power-on", 8'h5D, cfg.deviation_value);
        raw(24'hE00000);
        chk("delay code", 8, cfg.recovered_clock_delay_code);
        chk("delay unused", 0, dly);
        chk("bias code", 0, cfg.pa_bias_code);
        chk("rssi masked", 0, rssi);
        chk("digital out", 1, dig);
        chk("amp off delay", 2, cfg.amp_off_to_switch_delay);
        chk("divider offset", 8, cfg.divider_integer_offset);
        tuned = 1'b1;
        step(1);
        chk("rssi after tune", 1, rssi);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_CLK_TX, {5'h11, 3'(c), 8'h82});
            chk("bias level", c - (c >= 4), bias);
        end
        chk("delay applied", 8, dly);
        tuned = 1'b0;
        wr(ADDR_CLK_TX, 16'h7C7E);
        chk("delay applied 7", 7, dly);
        chk("rssi unmasked", 1, rssi);
        chk("vco recal", 0, vco);
        chk("if recal", 1, ifc);
        chk("one error", 1, uw);
        step(2);
        ref_clk = 1'b1;
        step(3);
        chk("tx rise ignored", 0, txf);
        ref_clk = 1'b0;
        step(3);
        chk("tx fall inverted", 1, txf);
        wr(ADDR_CLK_TX, 16'h0001);
        chk("regulator kept", 2, cfg.regulator_voltage_code);
        chk("other bits stored", 0, cfg.recovered_clock_delay_code);
        ref_clk = 1'b1;
        step(3);
        chk("tx rise plain", 0, txf);
        txd = 1'b1;
        ref_clk = 1'b0;
        step(3);
        ref_clk = 1'b1;
        step(3);
        chk("tx data passed", 1, txf);
        wr(ADDR_SWITCH, 16'h6351);
        chk("analog out", 1, ana);
        chk("digital off", 0, dig);
        chk("amp on delay", 3, cfg.amp_on_to_switch_delay);
        chk("amp off delay", 1, cfg.amp_off_to_switch_delay);
        chk("rx to tx field", 17, cfg.receive_to_transmit_delay);
        seq_run(1'b1);
        seq_run(1'b0);
        wr(ADDR_PLLOFS, 16'h0056);
        chk("divider offset 5", 5, cfg.divider_integer_offset);
        wr(ADDR_SWITCH, 16'h4000);
        chk("recommended amp off", 0, cfg.amp_off_to_switch_delay);
        chk("recommended digital", 1, dig);
        wr(ADDR_PLLOFS, 16'h8880);
        chk("recommended offset", 8, cfg.divider_integer_offset);
        wr(ADDR_DEVIAT, 16'h5200);
        chk("deviation", 8'h52, cfg.deviation_value);
        act = 1'b1;
        wr(ADDR_DEVIAT, 16'h1100);
        act = 1'b0;
        raw(24'h841100);
        raw(24'h241100);
        chk("refused words", 8'h52, cfg.deviation_value);
        for (int r = 0; r < 8; r++)
        begin
            rate = 3'(r);
            raw(24'hE00000);
            chk("rate default", dev_tab[r], cfg.deviation_value);
        end
        chk("defaults back", 2, cfg.amp_off_to_switch_delay);
        stop_test();
    end
endmodule // tb_tcr_config_bank
